/* File: dmp_pkg.sv */
// Package for the data master ports with thread tag
package dmp_pkg;
   localparam int ADDR_W_DEF = 32;
   localparam int THREAD_W_DEF = 4;
   localparam int NUM_CTX_DEF = 16;
   localparam int RECEIVE_IDENTIFIER_W_DEF = 4;
   localparam int TRANSMIT_IDENTIFIER_W_DEF = 4;
   localparam int DATA_W = 32;
   localparam int LANE_W = 4;
   localparam int FIX_LAT = 2;
   localparam logic [3:0] LANES_NONE = 4'h0;
   localparam logic [31:0] DATA_ZERO = 32'h0;

   // Access size requested by the core
   typedef enum logic [1:0] {DMP_SZ_BYTE, DMP_SZ_HALF, DMP_SZ_WORD} dmp_size_t;

   // One core access request
   typedef struct packed {
      logic rd;
      logic wr;
      dmp_size_t size;
      logic [31:0] wdata;
   } dmp_core_req_t;
endpackage

/* File: dmp_data_master.sv */
// Fixed- and variable-latency data master ports with thread tag
//
// Function
// - Both ports run on the core clock only.
// - Fixed port captures read data exactly two cycles after the read strobe.
// - Address is valid whenever the read strobe is high.
// - Address, lane mask and write data valid whenever write strobe high.
// - Address is a byte address of parameterised width.
// - Variable port holds request and all request signals during waitrequest.
// - Variable port captures read data only when readdatavalid is high.
// - Lowest-addressed byte lands in the most significant register position.
// - Bytes are swapped in hardware against little-endian bus lanes.
// - Each port drives a task tag with thread, context, receive, transmit ids.
// - Tag packs thread, context, receive, transmit from msb, no padding.
// - Context field width is log2 of the number of contexts.
`timescale 1ns/1ps
module dmp_data_master #(
   parameter int ADDR_W = dmp_pkg::ADDR_W_DEF,
   parameter int THREAD_W = dmp_pkg::THREAD_W_DEF,
   parameter int NUM_CTX = dmp_pkg::NUM_CTX_DEF,
   parameter int RECEIVE_IDENTIFIER_W = dmp_pkg::RECEIVE_IDENTIFIER_W_DEF,
   parameter int TRANSMIT_IDENTIFIER_W = dmp_pkg::TRANSMIT_IDENTIFIER_W_DEF,
   parameter int CTX_W = $clog2(NUM_CTX),
   parameter int TAG_W = THREAD_W + CTX_W + RECEIVE_IDENTIFIER_W + TRANSMIT_IDENTIFIER_W
) (
   input wire logic core_clk,
   input wire logic rst_b,
   // Core side, fixed port
   input wire logic fx_req_valid,
   input wire dmp_pkg::dmp_core_req_t fx_req,
   input wire logic [ADDR_W-1:0] fx_req_addr,
   input wire logic [THREAD_W-1:0] fx_thread,
   input wire logic [CTX_W-1:0] fx_context_identifier,
   input wire logic [RECEIVE_IDENTIFIER_W-1:0] fx_receive_identifier,
   input wire logic [TRANSMIT_IDENTIFIER_W-1:0] fx_transmit_identifier,
   output logic fx_rsp_valid,
   output logic [31:0] fx_rsp_data,
   // Core side, variable port
   input wire logic vl_req_valid,
   output logic vl_req_ready,
   input wire dmp_pkg::dmp_core_req_t vl_req,
   input wire logic [ADDR_W-1:0] vl_req_addr,
   input wire logic [THREAD_W-1:0] vl_thread,
   input wire logic [CTX_W-1:0] vl_context_identifier,
   input wire logic [RECEIVE_IDENTIFIER_W-1:0] vl_receive_identifier,
   input wire logic [TRANSMIT_IDENTIFIER_W-1:0] vl_transmit_identifier,
   output logic vl_rsp_valid,
   output logic [31:0] vl_rsp_data,
   // Fixed-latency bus master
   output logic fx_read,
   output logic fx_write,
   output logic [ADDR_W-1:0] fx_address,
   output logic [31:0] fx_writedata,
   output logic [3:0] fx_byteenable,
   input wire logic [31:0] fx_readdata,
   output logic [TAG_W-1:0] fx_threadinfo_data,
   // Variable-latency bus master
   output logic vl_read,
   output logic vl_write,
   output logic [ADDR_W-1:0] vl_address,
   output logic [31:0] vl_writedata,
   output logic [3:0] vl_byteenable,
   input wire logic vl_waitrequest,
   input wire logic vl_readdatavalid,
   input wire logic [31:0] vl_readdata,
   output logic [TAG_W-1:0] vl_threadinfo_data
);

   ////////////////////////////////////////////////////////////////////////////
   // Byte order helpers

   // Lane mask for a big-endian access; low address bits pick the lanes
   function automatic logic [3:0] lanes(input dmp_pkg::dmp_size_t sz, input logic [1:0] a);
      logic [3:0] m;
      m = dmp_pkg::LANES_NONE;
      case (sz)
         dmp_pkg::DMP_SZ_BYTE: m = 4'h1 << a;
         dmp_pkg::DMP_SZ_HALF: m = a[1] ? 4'hc : 4'h3;
         default: m = 4'hf;
      endcase
      return m;
   endfunction

   // Register value to bus lanes: lowest address byte taken from the register msb
   function automatic logic [31:0] to_bus(input dmp_pkg::dmp_size_t sz, input logic [1:0] a,
                                          input logic [31:0] v);
      logic [31:0] d;
      d = dmp_pkg::DATA_ZERO;
      case (sz)
         dmp_pkg::DMP_SZ_BYTE: d = {4{v[7:0]}};
         dmp_pkg::DMP_SZ_HALF: d = {2{v[7:0], v[15:8]}};
         default: d = {v[7:0], v[15:8], v[23:16], v[31:24]};
      endcase
      return d;
   endfunction

   // Bus lanes to register value, zero extended
   function automatic logic [31:0] from_bus(input dmp_pkg::dmp_size_t sz, input logic [1:0] a,
                                            input logic [31:0] d);
      logic [31:0] v;
      logic [7:0] b0;
      logic [7:0] b1;
      v = dmp_pkg::DATA_ZERO;
      b0 = d[8*a +: 8];
      b1 = a[1] ? d[31:24] : d[15:8];
      case (sz)
         dmp_pkg::DMP_SZ_BYTE: v = {24'h0, b0};
         dmp_pkg::DMP_SZ_HALF: v = {16'h0, (a[1] ? d[23:16] : d[7:0]), b1};
         default: v = {d[7:0], d[15:8], d[23:16], d[31:24]};
      endcase
      return v;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Decoding

   // Write wins a doubly flagged request so only one strobe ever rises
   wire fx_do_wr = fx_req_valid & fx_req.wr;
   wire fx_do_rd = fx_req_valid & fx_req.rd & ~fx_req.wr;
   wire vl_do_wr = vl_req_valid & vl_req.wr;
   wire vl_do_rd = vl_req_valid & vl_req.rd & ~vl_req.wr;
   wire [1:0] fx_lo = fx_req_addr[1:0];
   wire [1:0] vl_lo = vl_req_addr[1:0];
   wire [TAG_W-1:0] fx_tag = {fx_thread, fx_context_identifier, fx_receive_identifier,
                              fx_transmit_identifier};
   wire [TAG_W-1:0] vl_tag = {vl_thread, vl_context_identifier, vl_receive_identifier,
                              vl_transmit_identifier};

   ////////////////////////////////////////////////////////////////////////////
   // Fixed-latency port

   logic fx_read_r;
   logic fx_write_r;
   logic [ADDR_W-1:0] fx_address_r;
   logic [31:0] fx_writedata_r;
   logic [3:0] fx_byteenable_r;
   logic [TAG_W-1:0] fx_tag_r;
   logic [dmp_pkg::FIX_LAT-1:0] fx_pend_r;
   dmp_pkg::dmp_size_t fx_size_r;
   dmp_pkg::dmp_size_t fx_size_d_r;
   // Third stage lines the size up with the edge that samples the read data
   dmp_pkg::dmp_size_t fx_size_dd_r;
   logic [1:0] fx_lo_r;
   logic [1:0] fx_lo_d_r;
   logic [1:0] fx_lo_dd_r;
   logic fx_rsp_valid_r;
   logic [31:0] fx_rsp_data_r;

   always_ff @(posedge core_clk)
   begin
      if (!rst_b)
      begin
         fx_read_r <= 1'b0;
         fx_write_r <= 1'b0;
         fx_address_r <= '0;
         fx_writedata_r <= dmp_pkg::DATA_ZERO;
         fx_byteenable_r <= dmp_pkg::LANES_NONE;
         fx_tag_r <= '0;
      end
      else
      begin
         fx_read_r <= fx_do_rd;
         fx_write_r <= fx_do_wr;
         fx_address_r <= fx_req_addr;
         fx_writedata_r <= to_bus(fx_req.size, fx_lo, fx_req.wdata);
         fx_byteenable_r <= fx_do_wr ? lanes(fx_req.size, fx_lo) : dmp_pkg::LANES_NONE;
         fx_tag_r <= fx_tag;
      end
   end

   // Read data is taken on the third edge after the strobe edge; no stall exists
   always_ff @(posedge core_clk)
   begin
      if (!rst_b)
      begin
         fx_pend_r <= '0;
         fx_size_r <= dmp_pkg::DMP_SZ_WORD;
         fx_size_d_r <= dmp_pkg::DMP_SZ_WORD;
         fx_size_dd_r <= dmp_pkg::DMP_SZ_WORD;
         fx_lo_r <= 2'h0;
         fx_lo_d_r <= 2'h0;
         fx_lo_dd_r <= 2'h0;
         fx_rsp_valid_r <= 1'b0;
         fx_rsp_data_r <= dmp_pkg::DATA_ZERO;
      end
      else
      begin
         fx_pend_r <= {fx_pend_r[dmp_pkg::FIX_LAT-2:0], fx_read_r};
         fx_size_r <= fx_req.size;
         fx_size_d_r <= fx_size_r;
         fx_size_dd_r <= fx_size_d_r;
         fx_lo_r <= fx_lo;
         fx_lo_d_r <= fx_lo_r;
         fx_lo_dd_r <= fx_lo_d_r;
         fx_rsp_valid_r <= fx_pend_r[dmp_pkg::FIX_LAT-1];
         if (fx_pend_r[dmp_pkg::FIX_LAT-1])
            fx_rsp_data_r <= from_bus(fx_size_dd_r, fx_lo_dd_r, fx_readdata);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Variable-latency port

   logic vl_read_r;
   logic vl_write_r;
   logic [ADDR_W-1:0] vl_address_r;
   logic [31:0] vl_writedata_r;
   logic [3:0] vl_byteenable_r;
   logic [TAG_W-1:0] vl_tag_r;
   logic vl_req_ready_r;
   dmp_pkg::dmp_size_t vl_size_r;
   logic [1:0] vl_lo_r;
   logic vl_rsp_valid_r;
   logic [31:0] vl_rsp_data_r;

   // A stalled strobe freezes the whole request, ready included
   wire vl_busy = (vl_read_r | vl_write_r) & vl_waitrequest;
   wire vl_accept = vl_req_ready_r & (vl_do_rd | vl_do_wr);

   // One access at a time: size and lanes are kept until its data returns
   always_ff @(posedge core_clk)
   begin
      if (!rst_b)
      begin
         vl_read_r <= 1'b0;
         vl_write_r <= 1'b0;
         vl_address_r <= '0;
         vl_writedata_r <= dmp_pkg::DATA_ZERO;
         vl_byteenable_r <= dmp_pkg::LANES_NONE;
         vl_tag_r <= '0;
         vl_size_r <= dmp_pkg::DMP_SZ_WORD;
         vl_lo_r <= 2'h0;
         vl_req_ready_r <= 1'b1;
      end
      else if (vl_busy)
      begin
         vl_req_ready_r <= 1'b0;
      end
      else if (vl_accept)
      begin
         vl_read_r <= vl_do_rd;
         vl_write_r <= vl_do_wr;
         vl_address_r <= vl_req_addr;
         vl_writedata_r <= to_bus(vl_req.size, vl_lo, vl_req.wdata);
         vl_byteenable_r <= vl_do_wr ? lanes(vl_req.size, vl_lo) : dmp_pkg::LANES_NONE;
         vl_tag_r <= vl_tag;
         vl_size_r <= vl_req.size;
         vl_lo_r <= vl_lo;
         vl_req_ready_r <= 1'b0;
      end
      else
      begin
         vl_read_r <= 1'b0;
         vl_write_r <= 1'b0;
         vl_byteenable_r <= dmp_pkg::LANES_NONE;
         if (vl_write_r | (vl_readdatavalid & ~vl_read_r))
            vl_req_ready_r <= 1'b1;
      end
   end

   always_ff @(posedge core_clk)
   begin
      if (!rst_b)
      begin
         vl_rsp_valid_r <= 1'b0;
         vl_rsp_data_r <= dmp_pkg::DATA_ZERO;
      end
      else
      begin
         vl_rsp_valid_r <= vl_readdatavalid;
         if (vl_readdatavalid)
            vl_rsp_data_r <= from_bus(vl_size_r, vl_lo_r, vl_readdata);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs

   assign fx_read = fx_read_r;
   assign fx_write = fx_write_r;
   assign fx_address = fx_address_r;
   assign fx_writedata = fx_writedata_r;
   assign fx_byteenable = fx_byteenable_r;
   assign fx_threadinfo_data = fx_tag_r;
   assign fx_rsp_valid = fx_rsp_valid_r;
   assign fx_rsp_data = fx_rsp_data_r;
   assign vl_read = vl_read_r;
   assign vl_write = vl_write_r;
   assign vl_address = vl_address_r;
   assign vl_writedata = vl_writedata_r;
   assign vl_byteenable = vl_byteenable_r;
   assign vl_threadinfo_data = vl_tag_r;
   assign vl_req_ready = vl_req_ready_r;
   assign vl_rsp_valid = vl_rsp_valid_r;
   assign vl_rsp_data = vl_rsp_data_r;

endmodule

/* File: dmp_data_master_sva.sv */
// Assertion checker for the data master ports
`timescale 1ns/1ps
module dmp_data_master_sva #(
   parameter int ADDR_W = 32,
   parameter int TAG_W = 16
) (
   input wire logic core_clk,
   input wire logic rst_b,
   input wire logic fx_req_valid,
   input wire dmp_pkg::dmp_core_req_t fx_req,
   input wire logic fx_rsp_valid,
   input wire logic vl_req_valid,
   input wire logic vl_req_ready,
   input wire dmp_pkg::dmp_core_req_t vl_req,
   input wire logic vl_rsp_valid,
   input wire logic fx_read,
   input wire logic fx_write,
   input wire logic [3:0] fx_byteenable,
   input wire logic vl_read,
   input wire logic vl_write,
   input wire logic [ADDR_W-1:0] vl_address,
   input wire logic [31:0] vl_writedata,
   input wire logic [3:0] vl_byteenable,
   input wire logic vl_waitrequest,
   input wire logic vl_readdatavalid,
   input wire logic [TAG_W-1:0] vl_threadinfo_data
);
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!rst_b);
   a_fx_excl: assert property (!(fx_read && fx_write))
      else $error("fx read and write together");
   a_vl_excl: assert property (!(vl_read && vl_write))
      else $error("vl read and write together");
   a_fx_latency: assert property (fx_read |-> ##3 fx_rsp_valid)
      else $error("fx read data not taken after two cycles");
   a_fx_rsp_cause: assert property (fx_rsp_valid |-> $past(fx_read, 3))
      else $error("fx response without read");
   a_fx_read_src: assert property (fx_read |-> $past(fx_req_valid && fx_req.rd && !fx_req.wr))
      else $error("fx read without core read");
   a_fx_be_idle: assert property (!fx_write |-> fx_byteenable == 4'h0)
      else $error("fx lane mask outside write");
   a_vl_hold: assert property ((vl_read || vl_write) && vl_waitrequest |=>
      $stable({vl_read, vl_write, vl_address, vl_writedata, vl_byteenable, vl_threadinfo_data}))
      else $error("vl request moved while stalled");
   a_vl_rsp_take: assert property (vl_readdatavalid |=> vl_rsp_valid)
      else $error("vl read data dropped");
   a_vl_rsp_cause: assert property (vl_rsp_valid |-> $past(vl_readdatavalid))
      else $error("vl response without valid data");
   a_vl_busy: assert property (vl_req_valid && vl_req_ready && (vl_req.rd || vl_req.wr) |=>
      !vl_req_ready && (vl_read || vl_write))
      else $error("vl request not issued");
endmodule
bind dmp_data_master dmp_data_master_sva #(.ADDR_W(ADDR_W), .TAG_W(TAG_W)) u_sva (.*);

/* File: dmp_mem_model.sv */
// Data memory model with a fixed and a stalling port
`timescale 1ns/1ps
module dmp_mem_model (
   input wire logic core_clk,
   input wire logic [3:0] stall_n,
   input wire logic fx_read,
   input wire logic fx_write,
   input wire logic [31:0] fx_address,
   input wire logic [31:0] fx_writedata,
   input wire logic [3:0] fx_byteenable,
   output logic [31:0] fx_readdata,
   input wire logic vl_read,
   input wire logic vl_write,
   input wire logic [31:0] vl_address,
   input wire logic [31:0] vl_writedata,
   input wire logic [3:0] vl_byteenable,
   output logic vl_waitrequest,
   output logic vl_readdatavalid,
   output logic [31:0] vl_readdata
);
   logic [31:0] mem [0:15];
   logic [31:0] fx_p, vl_p;
   logic fx_v, vl_v;
   logic [3:0] wait_cnt = 4'h0;
   initial
   begin
      foreach (mem[i]) mem[i] = 32'h0;
      fx_readdata = 32'h0;
      vl_readdata = 32'h0;
      vl_readdatavalid = 1'b0;
   end
   assign vl_waitrequest = (vl_read || vl_write) && wait_cnt != stall_n;
   // Lane 0 is the lowest byte address
   task automatic put(input logic [31:0] a, input logic [31:0] d, input logic [3:0] be);
      for (int i = 0; i < 4; i++)
         if (be[i]) mem[a[5:2]][8*i +: 8] = d[8*i +: 8];
   endtask
   always @(posedge core_clk)
   begin
      wait_cnt <= vl_waitrequest ? wait_cnt + 4'h1 : 4'h0;
      if (fx_write) put(fx_address, fx_writedata, fx_byteenable);
      if (vl_write && !vl_waitrequest) put(vl_address, vl_writedata, vl_byteenable);
      fx_v <= fx_read;
      fx_p <= mem[fx_address[5:2]];
      // Bus shows junk outside the data phase
      fx_readdata <= fx_v ? fx_p : ~fx_readdata;
      vl_v <= vl_read && !vl_waitrequest;
      vl_p <= mem[vl_address[5:2]];
      vl_readdatavalid <= vl_v;
      vl_readdata <= vl_v ? vl_p : ~vl_readdata;
   end
endmodule

/* File: tb.sv */
// Testbench for the data master ports
`timescale 1ns/1ps
module tb;
   logic core_clk, rst_b, fx_req_valid, vl_req_valid, fx_rsp_valid, vl_rsp_valid, vl_req_ready;
   dmp_pkg::dmp_core_req_t rq;
   logic [31:0] ra, fx_rsp_data, vl_rsp_data, fx_address, vl_address, fx_writedata, vl_writedata;
   logic [31:0] fx_readdata, vl_readdata, q;
   logic [3:0] thr, ctx, rxi, txi, stall_n, fx_byteenable, vl_byteenable;
   logic [15:0] fx_threadinfo_data, vl_threadinfo_data;
   logic fx_read, fx_write, vl_read, vl_write, vl_waitrequest, vl_readdatavalid;
   int failures = 0;
   int samples_checked = 0;
   dmp_data_master u_dut (.*, .fx_req(rq), .vl_req(rq), .fx_req_addr(ra), .vl_req_addr(ra),
      .fx_thread(thr), .fx_context_identifier(ctx), .fx_receive_identifier(rxi), .fx_transmit_identifier(txi),
      .vl_thread(thr), .vl_context_identifier(ctx), .vl_receive_identifier(rxi), .vl_transmit_identifier(txi));
   dmp_mem_model u_mem (.*);
   initial
   begin
      core_clk = 1'b0;
      forever #50 core_clk = ~core_clk;
   end
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      samples_checked++;
      if (g !== e)
      begin
         failures++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask
   // One access; the tag changes every time so a stale tag shows
   task automatic op(input bit vp, input bit wr, input dmp_pkg::dmp_size_t sz, input logic [31:0] a,
                     input logic [31:0] d);
      @(negedge core_clk);
      rq = '{rd: !wr, wr: wr, size: sz, wdata: d};
      ra = a;
      {thr, ctx, rxi, txi} = {thr, ctx, rxi, txi} + 16'h1357;
      fx_req_valid = !vp;
      vl_req_valid = vp;
      @(negedge core_clk);
      fx_req_valid = 1'b0;
      vl_req_valid = 1'b0;
      chk("strobe", {30'h0, !wr, wr}, vp ? {30'h0, vl_read, vl_write} : {30'h0, fx_read, fx_write});
      chk("tag", {16'h0, thr, ctx, rxi, txi}, {16'h0, vp ? vl_threadinfo_data : fx_threadinfo_data});
      if (!vp)
         repeat (3) @(negedge core_clk);
      for (int n = 0; vp && n < 40 && !(wr ? vl_req_ready : vl_rsp_valid); n++)
         @(negedge core_clk);
      // A stalled write that never finishes must count, not slip through
      if (vp && wr)
         chk("write done", 32'h1, {31'h0, vl_req_ready});
      if (!wr)
         chk("response valid", 32'h1, {31'h0, vp ? vl_rsp_valid : fx_rsp_valid});
      q = vp ? vl_rsp_data : fx_rsp_data;
      @(negedge core_clk);
   endtask
   task automatic t_order(input bit vp, input logic [31:0] b);
      op(vp, 1'b1, dmp_pkg::DMP_SZ_WORD, b, 32'h0a0b0c0d);
      op(vp, 1'b0, dmp_pkg::DMP_SZ_BYTE, b + 1, 32'h0);
      chk("byte read", 32'h0000000b, q);
      op(vp, 1'b0, dmp_pkg::DMP_SZ_HALF, b + 2, 32'h0);
      chk("half read", 32'h00000c0d, q);
      op(vp, 1'b1, dmp_pkg::DMP_SZ_BYTE, b + 3, 32'h000000ee);
      op(vp, 1'b0, dmp_pkg::DMP_SZ_WORD, b, 32'h0);
      chk("word read", 32'h0a0b0cee, q);
   endtask
   task automatic t_fixed_port();
      t_order(1'b0, 32'h8);
      $display("test fixed port done");
   endtask
   task automatic t_var_stall();
      stall_n = 4'h3;
      t_order(1'b1, 32'h20);
      $display("test variable port with stalls done");
   endtask
   task automatic t_cross_port();
      stall_n = 4'h0;
      op(1'b1, 1'b0, dmp_pkg::DMP_SZ_WORD, 32'h8, 32'h0);
      chk("cross read", 32'h0a0b0cee, q);
      $display("test cross port done");
   endtask
   // Back-to-back reads of differing size catch a misaligned size pipeline
   task automatic t_fixed_burst();
      op(1'b0, 1'b1, dmp_pkg::DMP_SZ_HALF, 32'h10, 32'h00001234);
      @(negedge core_clk);
      rq = '{rd: 1'b1, wr: 1'b0, size: dmp_pkg::DMP_SZ_WORD, wdata: 32'h0};
      ra = 32'h10;
      fx_req_valid = 1'b1;
      @(negedge core_clk);
      rq.size = dmp_pkg::DMP_SZ_BYTE;
      ra = 32'h11;
      @(negedge core_clk);
      fx_req_valid = 1'b0;
      repeat (2) @(negedge core_clk);
      chk("burst valid", 32'h1, {31'h0, fx_rsp_valid});
      chk("burst first", 32'h12340000, fx_rsp_data);
      @(negedge core_clk);
      chk("burst second", 32'h00000034, fx_rsp_data);
      $display("test fixed burst done");
   endtask
   task automatic give_verdict();
      $display("checked %0d mismatches %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   initial
   begin
      rst_b = 1'b0;
      fx_req_valid = 1'b0;
      vl_req_valid = 1'b0;
      rq = '0;
      ra = 32'h0;
      {thr, ctx, rxi, txi} = 16'h0;
      stall_n = 4'h0;
      repeat (16) @(negedge core_clk);
      rst_b = 1'b1;
      chk("ready after reset", 32'h1, {31'h0, vl_req_ready});
      t_fixed_port();
      t_var_stall();
      t_cross_port();
      t_fixed_burst();
      give_verdict();
   end
   initial
   begin
      repeat (2000) @(posedge core_clk);
      failures++;
      give_verdict();
   end
endmodule
